// *** src/dtcm_top.sv ***
// Dual timer/counter with APB register access and a masked interrupt.
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dtcm_top (
    // Clock, reset and clock enable.
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic CLK_EN_I,
    // Register bus.
    input wire dtcm_pkg::dtcm_apb_req_type APB_REQ_I,
    output var dtcm_pkg::dtcm_apb_rsp_type APB_RSP_O,
    // Timer pins: bit 0 belongs to timer 0, bit 1 to timer 1.
    input wire logic [1:0] COUNT_PIN_I,
    input wire logic [1:0] GATE_PIN_I,
    input wire logic [1:0] INT_ACK_I,
    // Interrupt requests and baud tick.
    output logic [1:0] TIMER_IRQ_O,
    output logic IRQ_O,
    output logic BAUD_TICK_O
);
    import dtcm_pkg::*;

    dtcm_state_type st_ff;
    dtcm_state_type nxt_st;

    // Maps a bus address onto a register; used by both read and write paths.
    function automatic dtcm_reg_type reg_decode(input logic [11:0] addr);
        case (addr)
            DTCM_TIMER_CONTROL_REGISTER_ADDR: reg_decode = DTCM_REG_TIMER_CONTROL_REGISTER;
            DTCM_TIMER_MODE_REGISTER_ADDR: reg_decode = DTCM_REG_TIMER_MODE_REGISTER;
            DTCM_TL0_ADDR: reg_decode = DTCM_REG_TL0;
            DTCM_TH0_ADDR: reg_decode = DTCM_REG_TH0;
            DTCM_TL1_ADDR: reg_decode = DTCM_REG_TL1;
            DTCM_TH1_ADDR: reg_decode = DTCM_REG_TH1;
            DTCM_STS_ADDR: reg_decode = DTCM_REG_STS;
            DTCM_MASK_ADDR: reg_decode = DTCM_REG_MASK;
            default: reg_decode = DTCM_REG_NONE;
        endcase
    endfunction

    // One count step of a whole timer; returns {overflow, high, low}.
    function automatic logic [16:0] count_step(input logic [1:0] mode, input logic [7:0] lo,
                                               input logic [7:0] hi, input logic inc);
        logic [13:0] sum13;
        logic [16:0] sum16;
        sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
        sum16 = {1'b0, hi, lo} + 17'h00001;
        count_step = {1'b0, hi, lo};
        if (inc) begin
            case (mode)
                DTCM_MODE_13BIT: begin
                    // The upper three low-byte bits take no part in the count.
                    count_step = {sum13[13], sum13[12:5], lo[7:5], sum13[4:0]};
                end
                DTCM_MODE_16BIT: begin
                    count_step = sum16;
                end
                DTCM_MODE_RELOAD: begin
                    if (lo == 8'hff) begin
                        count_step = {1'b1, hi, hi};
                    end else begin
                        count_step = {1'b0, hi, sum16[7:0]};
                    end
                end
                default: begin
                    count_step = {1'b0, hi, lo};
                end
            endcase
        end
    endfunction

    // Bus access decode.
    logic acc;
    logic acc_w;
    dtcm_reg_type sel;
    assign sel = reg_decode(APB_REQ_I.paddr);
    assign acc = APB_REQ_I.psel & APB_REQ_I.penable & st_ff.rsp.pready;
    assign acc_w = acc & APB_REQ_I.pwrite;

    // Mode register fields.
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic t0_split;
    assign mode0 = st_ff.timer_mode_register[DTCM_MODE0_LSB +: 2];
    assign mode1 = st_ff.timer_mode_register[DTCM_MODE1_LSB +: 2];
    assign t0_split = (mode0 == DTCM_MODE_SPLIT);

    // Counted pin events are falling edges of the filtered pins.
    logic [1:0] evt;
    assign evt = st_ff.filt_d[1:0] & ~st_ff.filt[1:0];

    logic run0;
    logic run1;
    logic inc0;
    logic inc1;
    logic inc_h0;
    assign run0 = st_ff.timer_control_register[DTCM_TR0_BIT] &
                  (~st_ff.timer_mode_register[DTCM_GATE0_BIT] | st_ff.filt[2]);
    // While timer 0 is split, timer 1 ignores TR1 and is started and stopped by its own mode and its gate.
    assign run1 = (t0_split | st_ff.timer_control_register[DTCM_TR1_BIT]) &
                  (~st_ff.timer_mode_register[DTCM_GATE1_BIT] | st_ff.filt[3]) &
                  (mode1 != DTCM_MODE_SPLIT);
    assign inc0 = run0 & (st_ff.timer_mode_register[DTCM_CT0_BIT] ? evt[0] : 1'b1);
    assign inc1 = run1 & (st_ff.timer_mode_register[DTCM_CT1_BIT] ? evt[1] : 1'b1);
    assign inc_h0 = t0_split & st_ff.timer_control_register[DTCM_TR1_BIT];

    always_comb begin
        logic [16:0] res0;
        logic [16:0] res1;
        logic [8:0] lo_split;
        logic [8:0] hi_split;
        logic set0;
        logic set1;
        logic [7:0] wd;
        set0 = 1'b0;
        set1 = 1'b0;
        nxt_st = st_ff;
        res0 = count_step(mode0, st_ff.tl0, st_ff.th0, inc0);
        res1 = count_step(mode1, st_ff.tl1, st_ff.th1, inc1);
        lo_split = {1'b0, st_ff.tl0} + {8'h00, inc0};
        hi_split = {1'b0, st_ff.th0} + {8'h00, inc_h0};
        wd = APB_REQ_I.pwdata[7:0];

        // Pin synchronisers with agreement filter.
        nxt_st.sync1 = {GATE_PIN_I, COUNT_PIN_I};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.sync3 = st_ff.sync2;
        for (int i = 0; i < 4; i++) begin
            if (st_ff.sync2[i] == st_ff.sync3[i]) begin
                nxt_st.filt[i] = st_ff.sync3[i];
            end
        end
        nxt_st.filt_d = st_ff.filt;

        // Count registers advance; the run bit never clears them.
        if (t0_split) begin
            nxt_st.tl0 = lo_split[7:0];
            nxt_st.th0 = hi_split[7:0];
            set0 = lo_split[8];
            set1 = hi_split[8];
        end else begin
            nxt_st.th0 = res0[15:8];
            nxt_st.tl0 = res0[7:0];
            set0 = res0[16];
            set1 = res1[16];
        end
        nxt_st.th1 = res1[15:8];
        nxt_st.tl1 = res1[7:0];
        nxt_st.baud = res1[16];

        // Software writes to the count registers win over the count step.
        if (acc_w) begin
            case (sel)
                DTCM_REG_TIMER_CONTROL_REGISTER: begin
                    nxt_st.timer_control_register = wd;
                end
                DTCM_REG_TIMER_MODE_REGISTER: begin
                    nxt_st.timer_mode_register = wd;
                end
                DTCM_REG_TL0: begin
                    nxt_st.tl0 = wd;
                end
                DTCM_REG_TH0: begin
                    nxt_st.th0 = wd;
                end
                DTCM_REG_TL1: begin
                    nxt_st.tl1 = wd;
                end
                DTCM_REG_TH1: begin
                    nxt_st.th1 = wd;
                end
                DTCM_REG_STS: begin
                    nxt_st.sts = st_ff.sts & ~wd[1:0];
                end
                DTCM_REG_MASK: begin
                    nxt_st.mask = wd[1:0];
                end
                default: begin
                    nxt_st.timer_control_register = nxt_st.timer_control_register;
                end
            endcase
        end

        // Flags clear on interrupt service; a new overflow wins over any clear.
        if (INT_ACK_I[0]) begin
            nxt_st.timer_control_register[DTCM_TF0_BIT] = 1'b0;
        end
        if (INT_ACK_I[1]) begin
            nxt_st.timer_control_register[DTCM_TF1_BIT] = 1'b0;
        end
        if (set0) begin
            nxt_st.timer_control_register[DTCM_TF0_BIT] = 1'b1;
        end
        if (set1) begin
            nxt_st.timer_control_register[DTCM_TF1_BIT] = 1'b1;
        end
        nxt_st.sts = nxt_st.sts | {set1, set0};
        nxt_st.irq = |(st_ff.sts & st_ff.mask);

        // APB answer: one wait state, then data and error for one cycle.
        nxt_st.rsp.pready = APB_REQ_I.psel & APB_REQ_I.penable & ~st_ff.rsp.pready;
        nxt_st.rsp.pslverr = 1'b0;
        nxt_st.rsp.prdata = 32'h0000_0000;
        if (nxt_st.rsp.pready) begin
            nxt_st.rsp.pslverr = (sel == DTCM_REG_NONE);
            case (sel)
                DTCM_REG_TIMER_CONTROL_REGISTER: nxt_st.rsp.prdata = {24'h000000, st_ff.timer_control_register};
                DTCM_REG_TIMER_MODE_REGISTER: nxt_st.rsp.prdata = {24'h000000, st_ff.timer_mode_register};
                DTCM_REG_TL0: nxt_st.rsp.prdata = {24'h000000, st_ff.tl0};
                DTCM_REG_TH0: nxt_st.rsp.prdata = {24'h000000, st_ff.th0};
                DTCM_REG_TL1: nxt_st.rsp.prdata = {24'h000000, st_ff.tl1};
                DTCM_REG_TH1: nxt_st.rsp.prdata = {24'h000000, st_ff.th1};
                DTCM_REG_STS: nxt_st.rsp.prdata = {30'h00000000, st_ff.sts};
                DTCM_REG_MASK: nxt_st.rsp.prdata = {30'h00000000, st_ff.mask};
                default: nxt_st.rsp.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            st_ff <= DTCM_STATE_RST;
        end else if (CLK_EN_I) begin
            st_ff <= nxt_st;
        end
    end

    assign APB_RSP_O = st_ff.rsp;
    assign TIMER_IRQ_O = {st_ff.timer_control_register[DTCM_TF1_BIT], st_ff.timer_control_register[DTCM_TF0_BIT]};
    assign IRQ_O = st_ff.irq;
    assign BAUD_TICK_O = st_ff.baud;

    default clocking dtcm_cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    a_mode0_wrap: assert property (
        CLK_EN_I && !acc_w && mode0 == DTCM_MODE_13BIT && inc0 &&
        {st_ff.th0, st_ff.tl0[4:0]} == 13'h1fff
        |=> st_ff.timer_control_register[DTCM_TF0_BIT] && st_ff.th0 == 8'h00 && st_ff.tl0[4:0] == 5'h00 &&
            st_ff.tl0[7:5] == $past(st_ff.tl0[7:5]))
        else $error("Mode 0 roll-over did not clear the count and set the flag.");

    a_gate_hold: assert property (
        CLK_EN_I && !acc_w && !t0_split && (!st_ff.timer_control_register[DTCM_TR0_BIT] ||
        (st_ff.timer_mode_register[DTCM_GATE0_BIT] && !st_ff.filt[2]))
        |=> st_ff.tl0 == $past(st_ff.tl0) && st_ff.th0 == $past(st_ff.th0))
        else $error("Timer 0 counted while stopped or gated off.");

    a_run_keeps: assert property (
        CLK_EN_I && acc_w && sel == DTCM_REG_TIMER_CONTROL_REGISTER && !st_ff.timer_control_register[DTCM_TR0_BIT] &&
        !t0_split && APB_REQ_I.pwdata[DTCM_TR0_BIT]
        |=> st_ff.timer_control_register[DTCM_TR0_BIT] && $stable(st_ff.tl0) && $stable(st_ff.th0))
        else $error("Setting the run bit changed the timer 0 count.");

    a_mode1_carry: assert property (
        CLK_EN_I && !acc_w && mode1 == DTCM_MODE_16BIT && inc1 && st_ff.tl1 == 8'hff
        |=> st_ff.tl1 == 8'h00 && st_ff.th1 == $past(st_ff.th1) + 8'h01)
        else $error("Mode 1 low byte did not carry into the high byte.");

    a_reload_low: assert property (
        CLK_EN_I && !acc_w && mode0 == DTCM_MODE_RELOAD && inc0 && st_ff.tl0 == 8'hff
        |=> st_ff.tl0 == $past(st_ff.th0) && $stable(st_ff.th0) && st_ff.timer_control_register[DTCM_TF0_BIT])
        else $error("Mode 2 overflow did not reload the low byte.");

    a_t1_hold: assert property (
        CLK_EN_I && !acc_w && mode1 == DTCM_MODE_SPLIT |=> $stable({st_ff.th1, st_ff.tl1}))
        else $error("Timer 1 in mode 3 changed its count.");

    a_split_low: assert property (
        CLK_EN_I && !acc_w && t0_split && inc0 && st_ff.tl0 == 8'hff
        |=> st_ff.tl0 == 8'h00 && st_ff.timer_control_register[DTCM_TF0_BIT] && $stable(st_ff.th0) == !$past(inc_h0))
        else $error("Split low byte overflow misbehaved.");

    a_split_high: assert property (
        CLK_EN_I && !acc_w && t0_split && st_ff.timer_control_register[DTCM_TR1_BIT] && st_ff.th0 == 8'hff
        |=> st_ff.th0 == 8'h00 && st_ff.timer_control_register[DTCM_TF1_BIT] ##1 (IRQ_O || !st_ff.mask[1]))
        else $error("Split high byte overflow did not raise the timer 1 flag.");

    a_t1_quiet: assert property (
        CLK_EN_I && !acc_w && t0_split && !inc_h0 && !st_ff.timer_control_register[DTCM_TF1_BIT]
        |=> !st_ff.timer_control_register[DTCM_TF1_BIT])
        else $error("Timer 1 raised its own flag while timer 0 was split.");

    a_flag_sticky: assert property (
        CLK_EN_I && st_ff.timer_control_register[DTCM_TF0_BIT] && !INT_ACK_I[0] && !acc_w
        |=> st_ff.timer_control_register[DTCM_TF0_BIT] [*2] or (##1 !CLK_EN_I || INT_ACK_I[0] || acc_w))
        else $error("Timer 0 flag dropped without a clear.");

endmodule
`default_nettype wire

// *** include/dtcm_pkg.sv ***
// Constants, register map and carrier types of the dual timer/counter block.
package dtcm_pkg;

    localparam int DTCM_AW = 12;

    // Byte addresses of the registers.
    localparam logic [11:0] DTCM_TIMER_CONTROL_REGISTER_ADDR = 12'h088;
    localparam logic [11:0] DTCM_TIMER_MODE_REGISTER_ADDR = 12'h08c;
    localparam logic [11:0] DTCM_TL0_ADDR = 12'h090;
    localparam logic [11:0] DTCM_TH0_ADDR = 12'h094;
    localparam logic [11:0] DTCM_TL1_ADDR = 12'h098;
    localparam logic [11:0] DTCM_TH1_ADDR = 12'h09c;
    localparam logic [11:0] DTCM_STS_ADDR = 12'h0a0;
    localparam logic [11:0] DTCM_MASK_ADDR = 12'h0a4;

    // Control register fields.
    localparam int DTCM_TF1_BIT = 7;
    localparam int DTCM_TR1_BIT = 6;
    localparam int DTCM_TF0_BIT = 5;
    localparam int DTCM_TR0_BIT = 4;

    // Mode register fields.
    localparam int DTCM_GATE1_BIT = 7;
    localparam int DTCM_CT1_BIT = 6;
    localparam int DTCM_MODE1_LSB = 4;
    localparam int DTCM_GATE0_BIT = 3;
    localparam int DTCM_CT0_BIT = 2;
    localparam int DTCM_MODE0_LSB = 0;

    // Timer modes.
    localparam logic [1:0] DTCM_MODE_13BIT = 2'h0;
    localparam logic [1:0] DTCM_MODE_16BIT = 2'h1;
    localparam logic [1:0] DTCM_MODE_RELOAD = 2'h2;
    localparam logic [1:0] DTCM_MODE_SPLIT = 2'h3;

    // Values after reset.
    localparam logic [7:0] DTCM_TIMER_CONTROL_REGISTER_RST = 8'h00;
    localparam logic [7:0] DTCM_TIMER_MODE_REGISTER_RST = 8'h00;
    localparam logic [7:0] DTCM_COUNT_RST = 8'h00;
    localparam logic [1:0] DTCM_FLAGS_RST = 2'h0;
    localparam logic [3:0] DTCM_PINS_RST = 4'h0;

    typedef enum logic [3:0] {
        DTCM_REG_TIMER_CONTROL_REGISTER, DTCM_REG_TIMER_MODE_REGISTER, DTCM_REG_TL0, DTCM_REG_TH0,
        DTCM_REG_TL1, DTCM_REG_TH1, DTCM_REG_STS, DTCM_REG_MASK, DTCM_REG_NONE
    } dtcm_reg_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dtcm_apb_req_type;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } dtcm_apb_rsp_type;

    typedef struct packed {
        logic [7:0] timer_control_register;
        logic [7:0] timer_mode_register;
        logic [7:0] tl0;
        logic [7:0] th0;
        logic [7:0] tl1;
        logic [7:0] th1;
        logic [1:0] sts;
        logic [1:0] mask;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] sync3;
        logic [3:0] filt;
        logic [3:0] filt_d;
        dtcm_apb_rsp_type rsp;
        logic irq;
        logic baud;
    } dtcm_state_type;

    localparam dtcm_state_type DTCM_STATE_RST = '{
        timer_control_register: DTCM_TIMER_CONTROL_REGISTER_RST, timer_mode_register: DTCM_TIMER_MODE_REGISTER_RST,
        tl0: DTCM_COUNT_RST, th0: DTCM_COUNT_RST,
        tl1: DTCM_COUNT_RST, th1: DTCM_COUNT_RST,
        sts: DTCM_FLAGS_RST, mask: DTCM_FLAGS_RST,
        sync1: DTCM_PINS_RST, sync2: DTCM_PINS_RST, sync3: DTCM_PINS_RST,
        filt: DTCM_PINS_RST, filt_d: DTCM_PINS_RST,
        rsp: '{pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0},
        irq: 1'b0, baud: 1'b0
    };

endpackage

// *** testbench/dtcm_top_bench.sv ***
// Self-checking bench of the dual timer/counter block.
`timescale 1ns/1ps
`default_nettype none
module dtcm_top_bench;
    import dtcm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    dtcm_apb_req_type req = '0;
    dtcm_apb_rsp_type rsp;
    logic [1:0] count_pin = 2'h0;
    logic [1:0] gate_pin = 2'h0;
    logic [1:0] int_ack = 2'h0;
    logic [1:0] timer_irq;
    logic irq;
    logic baud;
    int bad_count = 0;
    int num_checks = 0;
    int baud_seen = 0;
    logic [31:0] seed = 32'h0000_002d;
    logic [7:0] rd;
    logic err;

    dtcm_top dut (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(clk_en),
        .APB_REQ_I(req), .APB_RSP_O(rsp),
        .COUNT_PIN_I(count_pin), .GATE_PIN_I(gate_pin), .INT_ACK_I(int_ack),
        .TIMER_IRQ_O(timer_irq), .IRQ_O(irq), .BAUD_TICK_O(baud)
    );

    always #10 clk = ~clk;

    always @(posedge clk) begin
        if (baud === 1'b1) begin
            baud_seen <= baud_seen + 1;
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Reference count: flag, high byte, low byte after n increments.
    function automatic logic [16:0] model(input logic [1:0] m, input logic [7:0] tl,
                                          input logic [7:0] th, input int n);
        int v;
        logic flag;
        flag = 1'b0;
        v = (m == DTCM_MODE_13BIT) ? {th, tl[4:0]} : (m == DTCM_MODE_16BIT) ? {th, tl} : tl;
        for (int i = 0; i < n; i++) begin
            if (m == DTCM_MODE_13BIT && v == 8191) begin
                v = 0;
                flag = 1'b1;
            end else if (m == DTCM_MODE_16BIT && v == 65535) begin
                v = 0;
                flag = 1'b1;
            end else if (m == DTCM_MODE_RELOAD && v == 255) begin
                v = th;
                flag = 1'b1;
            end else begin
                v = v + 1;
            end
        end
        if (m == DTCM_MODE_13BIT) begin
            return {flag, v[12:5], tl[7:5], v[4:0]};
        end
        if (m == DTCM_MODE_16BIT) begin
            return {flag, v[15:0]};
        end
        return {flag, th, v[7:0]};
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error land in rd and err.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1) begin
                break;
            end
        end
        if (k == 20) begin
            bad_count++;
            end_sim();
        end
        rd = rsp.prdata[7:0];
        err = rsp.pslverr;
        req <= '0;
    endtask

    task automatic pulse(input int idx, input int n);
        @(posedge clk);
        gate_pin[idx] <= 1'b1;
        repeat (n) @(posedge clk);
        gate_pin[idx] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic run_mode(input int idx, input logic [1:0] m, input logic [7:0] tl,
                            input logic [7:0] th, input int n);
        logic [16:0] e;
        logic [7:0] msk;
        logic [7:0] run;
        logic [11:0] la;
        logic [11:0] ha;
        e = model(m, tl, th, n);
        msk = (m == DTCM_MODE_13BIT) ? 8'h1f : 8'hff;
        run = (idx == 1) ? 8'h40 : 8'h10;
        la = (idx == 1) ? DTCM_TL1_ADDR : DTCM_TL0_ADDR;
        ha = (idx == 1) ? DTCM_TH1_ADDR : DTCM_TH0_ADDR;
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h00);
        apb(1'b1, DTCM_TIMER_MODE_REGISTER_ADDR, (idx == 1) ? {2'b10, m, 4'h0} : {4'h0, 2'b10, m});
        apb(1'b1, la, tl);
        apb(1'b1, ha, th);
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, run);
        pulse(idx, n);
        check({7'h0, timer_irq[idx]}, {7'h0, e[16]});
        apb(1'b0, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h00);
        check(rd, run | (e[16] ? (run << 1) : 8'h00));
        apb(1'b0, la, 8'h00);
        check(rd & msk, e[7:0] & msk);
        apb(1'b0, ha, 8'h00);
        check(rd, e[15:8]);
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h00);
        pulse(idx, 3);
        apb(1'b0, la, 8'h00);
        check(rd & msk, e[7:0] & msk);
        $display("test mode %0d timer %0d done", m, idx);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    initial begin
        int n;
        logic [7:0] r;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, DTCM_TIMER_CONTROL_REGISTER_ADDR + 12'(4 * i), 8'h00);
            check(rd, 8'h00);
        end
        apb(1'b1, 12'h0a8, 8'h5a);
        check({7'h0, err}, 8'h01);
        apb(1'b0, 12'h0a8, 8'h00);
        check(rd, 8'h00);
        $display("test reset and map done");
        for (int idx = 0; idx < 2; idx++) begin
            for (int m = 0; m < 3; m++) begin
                r = rnd();
                n = 1 + int'(rnd() % 6);
                run_mode(idx, 2'(m), (m == 2) ? 8'hfe : 8'hff, (m == 2) ? r : 8'hff, n);
            end
        end
        apb(1'b0, DTCM_STS_ADDR, 8'h00);
        check(rd, 8'h03);
        check({7'h0, irq}, 8'h00);
        apb(1'b1, DTCM_MASK_ADDR, 8'h01);
        repeat (3) @(posedge clk);
        check({7'h0, irq}, 8'h01);
        apb(1'b1, DTCM_STS_ADDR, 8'h01);
        repeat (3) @(posedge clk);
        check({7'h0, irq}, 8'h00);
        apb(1'b0, DTCM_STS_ADDR, 8'h00);
        check(rd, 8'h02);
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h20);
        repeat (2) @(posedge clk);
        check({6'h0, timer_irq}, 8'h01);
        int_ack <= 2'b01;
        @(posedge clk);
        int_ack <= 2'b00;
        repeat (2) @(posedge clk);
        check({6'h0, timer_irq}, 8'h00);
        $display("test interrupt done");
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h00);
        apb(1'b1, DTCM_TIMER_MODE_REGISTER_ADDR, 8'h50);
        apb(1'b1, DTCM_TL1_ADDR, 8'h00);
        apb(1'b1, DTCM_TH1_ADDR, 8'h00);
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h40);
        n = 1 + int'(rnd() % 7);
        repeat (n) begin
            count_pin[1] <= 1'b1;
            repeat (4) @(posedge clk);
            count_pin[1] <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h00);
        apb(1'b0, DTCM_TL1_ADDR, 8'h00);
        check(rd, 8'(n));
        $display("test counter done");
        apb(1'b1, DTCM_TIMER_MODE_REGISTER_ADDR, 8'h2b);
        apb(1'b1, DTCM_TL0_ADDR, 8'hff);
        apb(1'b1, DTCM_TH0_ADDR, 8'hfc);
        apb(1'b1, DTCM_TL1_ADDR, 8'hf0);
        apb(1'b1, DTCM_TH1_ADDR, 8'hf0);
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h10);
        pulse(0, 2);
        apb(1'b0, DTCM_TL0_ADDR, 8'h00);
        check(rd, 8'h01);
        apb(1'b0, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h00);
        check(rd, 8'h30);
        n = baud_seen;
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h50);
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h10);
        apb(1'b0, DTCM_TH0_ADDR, 8'h00);
        check(rd, 8'h00);
        apb(1'b0, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h00);
        check(rd, 8'h90);
        check({7'h0, baud_seen > n}, 8'h01);
        apb(1'b1, DTCM_TIMER_MODE_REGISTER_ADDR, 8'h31);
        apb(1'b1, DTCM_TL1_ADDR, 8'h55);
        apb(1'b1, DTCM_TIMER_CONTROL_REGISTER_ADDR, 8'h40);
        repeat (10) @(posedge clk);
        apb(1'b0, DTCM_TL1_ADDR, 8'h00);
        check(rd, 8'h55);
        $display("test split mode done");
        end_sim();
    end
endmodule
`default_nettype wire
